// file: dv/iss_sink.sv
// Output formatter model that takes words with pseudo-random stalls.
`timescale 1ns/100ps

// =====
// Sink
module iss_sink (
   input  wire logic          mclk,      // Clock.
   input  wire logic          rst_b,     // Reset, active low.
   input  wire logic          stall,     // Holds ready low.
   input  wire logic          out_valid, // Word offered.
   input  iss_pkg::iss_word_t out_data,  // Offered word.
   output logic               out_ready  // Word taken.
);
   logic [7:0]         lfsr;   // Stall pattern.
   iss_pkg::iss_word_t got[$]; // Taken words, oldest first.
   initial out_ready = 1'b0;
   // Ready follows a pseudo-random pattern, so the buffer meets stalls.
   always @(posedge mclk) begin
      if (!rst_b) begin
         lfsr <= 8'hA5;
         out_ready <= 1'b0;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         out_ready <= !stall && (lfsr[1:0] != 2'h0);
         // Every taken word, statistic or not, is queued whole in arrival order.
         if (out_valid && out_ready) got.push_back(out_data);
      end
   end
endmodule

// file: dv/iss_stats_sva.sv
// Concurrent checks on the ports of the iteration statistics unit.
`timescale 1ns/100ps

// =====
// Checker
module iss_stats_sva (
   input wire logic           mclk,            // Clock.
   input wire logic           rst_b,           // Reset, active low.
   input wire logic           ce,              // Clock enable.
   input wire logic           in_valid,        // Sample offered.
   input wire logic           in_ready,        // Sample taken.
   input iss_pkg::iss_sample_t in_data,        // Sample.
   input wire logic           out_valid,       // Word offered.
   input wire logic           out_ready,       // Word taken.
   input iss_pkg::iss_word_t  out_data,        // Word.
   input wire logic [7:0]     avs_address,     // Byte address.
   input wire logic           avs_read,        // Read request.
   input wire logic           avs_write,       // Write request.
   input wire logic [31:0]    avs_writedata,   // Write data.
   input wire logic [3:0]     avs_byteenable,  // Byte lanes.
   input wire logic [31:0]    avs_readdata,    // Read data.
   input wire logic           avs_waitrequest  // Stall.
);
   logic [1:0] sel_q;   // Output select as last written.
   logic       rd_ans;  // A read is answered in this cycle.
   assign rd_ans = avs_read && !avs_waitrequest;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // Track the select field, so output words can be judged by their mode.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sel_q <= 2'h0;
      end else if (ce && avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable[0]) begin
         sel_q <= avs_writedata[1:0];
      end
   end

   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_answer: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !ce || !avs_waitrequest)
      else $error("bus request not answered in the next cycle");
   a_peak_width: assert property (rd_ans && avs_address[4:2] == 3'h0 && avs_address[7:5] inside {[3'h1:3'h4]}
      |-> avs_readdata[31:24] == 8'h00) else $error("peak value wider than 24 bits");
   a_pos_width: assert property (rd_ans && avs_address[4:2] == 3'h1 && avs_address[7:5] inside {[3'h1:3'h4]}
      |-> avs_readdata[31:12] == 20'h00000) else $error("peak position wider than 12 bits");
   a_total_width: assert property (rd_ans && avs_address[4:2] inside {3'h3, 3'h5} && avs_address[7:5] inside {[3'h1:3'h4]}
      |-> avs_readdata[31:4] == 28'h0000000) else $error("total wider than 36 bits");
   a_count_cap: assert property (rd_ans && avs_address == 8'h04 |-> avs_readdata[2:0] <= 3'h4)
      else $error("more than four iterations recorded");
   a_unmapped_zero: assert property (rd_ans && avs_address[7:5] > 3'h4 |-> avs_readdata == 32'h00000000)
      else $error("record beyond the fourth block reads nonzero");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output word changed while stalled");
   a_stat_last: assert property (out_valid && out_data.stat |-> out_data.last)
      else $error("statistic word not closing an iteration");
   a_peak_q: assert property (out_valid && out_data.stat && sel_q == 2'h2 |-> out_data.q[23:12] == 12'h000)
      else $error("peak position word wider than 12 bits");
   a_main_plain: assert property (out_valid && !sel_q[1] |-> !out_data.stat)
      else $error("statistic word in main output mode");
endmodule

bind iss_stats iss_stats_sva i_sva (.mclk(mclk), .rst_b(rst_b), .ce(ce), .in_valid(in_valid), .in_ready(in_ready),
   .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// file: dv/iss_stats_tb.sv
// Self-checking testbench of the iteration statistics unit.
`timescale 1ns/100ps

// =====
// Bench
module iss_stats_tb;
   logic                 mclk, rst_b, ce, in_valid, in_ready, out_valid, out_ready, stall; // Ports and sink stall.
   logic                 avs_read, avs_write, avs_waitrequest;    // Bus handshake.
   logic [7:0]           avs_address;                             // Bus address.
   logic [31:0]          avs_writedata, avs_readdata, rng;        // Bus data and random state.
   logic [3:0]           avs_byteenable;                          // Bus lanes.
   iss_pkg::iss_sample_t in_data;                                 // Sample in.
   iss_pkg::iss_word_t   out_data;                                // Word out.
   iss_pkg::iss_word_t   exp_q[$];                                // Expected words.
   logic [23:0]          rec_pk[4];                               // Model peak records.
   logic [11:0]          rec_pos[4];                              // Model position records.
   logic [35:0]          rec_re[4], rec_im[4];                    // Model totals.
   int                   failures, checks_done, iters;            // Counters.

   iss_stats i_iss_stats (.mclk(mclk), .rst_b(rst_b), .ce(ce), .in_valid(in_valid), .in_ready(in_ready),
      .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   iss_sink i_iss_sink (.mclk(mclk), .rst_b(rst_b), .stall(stall), .out_valid(out_valid), .out_data(out_data),
      .out_ready(out_ready));

   // The clock runs at 25 MHz.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // A hang counts as a mismatch and closes the run.
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      wrap_up();
   end

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   // Signed limiter after the shift; only signed bounds exist.
   function automatic logic [23:0] sat(input longint v, input logic [4:0] sh);
      longint s;
      s = v >>> sh;
      if (s > 64'sh7FFFFF) return 24'h7FFFFF;
      if (s < -64'sh800000) return 24'h800000;
      return s[23:0];
   endfunction

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One bus access; an edge passes after release so the next one starts cleanly.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(r, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   // One iteration of eight samples; mode 1 forces ties, mode 2 forces large values.
   task automatic run_iter(input logic [1:0] sel, input logic mag, input logic lg, input logic [4:0] sh, input int mode);
      logic [23:0] i, q, pk;
      logic [11:0] pos;
      logic [31:0] r;
      longint      si, sq;
      pk = 24'h0;
      pos = 12'h0;
      si = 0;
      sq = 0;
      wr(8'h00, {19'h0, sh, 4'h0, lg, mag, sel});
      for (int j = 0; j < 8; j++) begin
         r = xs();
         i = r[23:0];
         r = xs();
         q = r[23:0];
         if (mode == 1) i = {21'h0, i[2:0]};
         if (mode == 2) begin
            i[23:21] = 3'h3;
            q[23:21] = 3'h4;
         end
         if ((mag || lg) && i > pk) begin
            pk = i;
            pos = j[11:0];
         end
         si += longint'($signed(i));
         sq += longint'($signed(q));
         if (!sel[1]) exp_q.push_back({i, q, j == 7, 1'b0});
         in_data <= {i, q, j == 7};
         in_valid <= 1'b1;
         do @(posedge mclk); while (in_ready !== 1'b1);
      end
      in_valid <= 1'b0;
      if (sel == 2'h2) exp_q.push_back({pk, 12'h000, pos, 1'b1, 1'b1});
      if (sel == 2'h3) exp_q.push_back({sat(si, sh), sat(sq, sh), 1'b1, 1'b1});
      if (iters < 4) begin
         rec_pk[iters] = pk;
         rec_pos[iters] = pos;
         rec_re[iters] = si[35:0];
         rec_im[iters] = sq[35:0];
      end
      iters++;
      for (int n = 0; n < 300 && i_iss_sink.got.size() < exp_q.size(); n++) @(posedge mclk);
      check(i_iss_sink.got.size(), exp_q.size());
      while (exp_q.size() > 0 && i_iss_sink.got.size() > 0) check(i_iss_sink.got.pop_front(), exp_q.pop_front());
      i_iss_sink.got.delete();
      exp_q.delete();
   endtask

   // Main sequence.
   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      stall = 1'b0;
      in_valid = 1'b0;
      in_data = '0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      rng = 32'h0000C907;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      for (int n = 1; n < 5; n++) for (int s = 0; s < 6; s++) rd(8'(32 * n + 4 * s), 32'h0);
      rd(8'hE0, 32'h0);
      // The sink stalls for 30 cycles, the buffer must refuse by then, then the sink drains it.
      stall <= 1'b1;
      fork
         begin
            repeat (30) @(posedge mclk);
            check(in_ready, 1'b0);
            stall <= 1'b0;
         end
         run_iter(2'h1, 1'b1, 1'b0, 5'h00, 0);
      join
      run_iter(2'h2, 1'b1, 1'b0, 5'h00, 1);
      run_iter(2'h3, 1'b1, 1'b0, 5'h00, 2);
      run_iter(2'h2, 1'b0, 1'b1, 5'h00, 0);
      run_iter(2'h3, 1'b0, 1'b0, 5'h0C, 0);
      run_iter(2'h0, 1'b1, 1'b0, 5'h1F, 0);
      rd(8'h04, 32'h4);
      rd(8'h00, 32'h00001F04);
      for (int n = 0; n < 4; n++) begin
         rd(8'(32 * n + 32), {8'h0, rec_pk[n]});
         rd(8'(32 * n + 36), {20'h0, rec_pos[n]});
         rd(8'(32 * n + 40), rec_re[n][31:0]);
         rd(8'(32 * n + 44), {28'h0, rec_re[n][35:32]});
         rd(8'(32 * n + 48), rec_im[n][31:0]);
         rd(8'(32 * n + 52), {28'h0, rec_im[n][35:32]});
      end
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, {8'h0, rec_pk[0]});
      wr(8'h00, 32'h80000000);
      rd(8'h04, 32'h0);
      rd(8'h24, {20'h0, rec_pos[0]});
      wrap_up();
   end
endmodule

// file: logic/iss_buf2.sv
// Two-entry buffer between the statistics unit and the output formatter.
`timescale 1ns/100ps

module iss_buf2 (
   input  wire logic          mclk,      // Datapath clock.
   input  wire logic          rst_b,     // Synchronous reset, active low.
   input  wire logic          ce,        // Clock enable; low freezes all.
   input  wire logic          in_valid,  // Word offered.
   output logic               in_ready,  // Room for a word.
   input  iss_pkg::iss_word_t in_data,   // Offered word.
   output logic               out_valid, // Head word valid.
   input  wire logic          out_ready, // Receiver takes head word.
   output iss_pkg::iss_word_t out_data   // Head word.
);

   // ========================================================================
   // Storage
   iss_pkg::iss_word_t tail_reg;   // Second entry, valid when two held.
   logic [1:0]         cnt_reg;    // Words held, 0 to 2.
   logic [1:0]         cnt_next;   // Next word count.
   logic               push;       // Word accepted this cycle.
   logic               pop;        // Word delivered this cycle.

   assign push = in_valid & in_ready;
   assign pop  = out_valid & out_ready;

   // Count follows pushes and pops; both at once leave it unchanged.
   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   // Flags are registered so the ports come straight from flip-flops.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt_reg   <= 2'h0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else if (ce) begin
         cnt_reg   <= cnt_next;
         in_ready  <= (cnt_next != 2'h2);
         out_valid <= (cnt_next != 2'h0);
      end
   end

   // Head always holds the oldest word, so the output needs no mux.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         out_data <= '0;
         tail_reg <= '0;
      end else if (ce) begin
         if (pop && cnt_reg == 2'h2) begin
            out_data <= tail_reg;
         end else if (push && (cnt_reg == 2'h0 || (pop && cnt_reg == 2'h1))) begin
            out_data <= in_data;
         end else if (push) begin
            tail_reg <= in_data;
         end
      end
   end

endmodule

// file: logic/iss_map.svh
// Register offsets, field positions and reset values of the iteration statistics unit.
`ifndef ISS_MAP_SVH
`define ISS_MAP_SVH

// ==========================================================================
// Register byte offsets
`define ISS_CTRL_OFS      8'h00
`define ISS_STAT_OFS      8'h04
// Result block n (0..3) starts at byte 0x20*(n+1); address bits 7:5 pick it.
`define ISS_RES_FIRST     3'h1
`define ISS_RES_LAST      3'h4
// Word slot inside a result block, address bits 4:2.
`define ISS_SLOT_PEAK     3'h0
`define ISS_SLOT_POS      3'h1
`define ISS_SLOT_RE_LO    3'h2
`define ISS_SLOT_RE_HI    3'h3
`define ISS_SLOT_IM_LO    3'h4
`define ISS_SLOT_IM_HI    3'h5

// ==========================================================================
// Control register fields
`define ISS_SEL_LSB       0
`define ISS_MAG_BIT       2
`define ISS_LOG_BIT       3
`define ISS_SHIFT_LSB     8
`define ISS_RESTART_BIT   31

// ==========================================================================
// Reset values and counts
`define ISS_SEL_RST       2'h0
`define ISS_SHIFT_RST     5'h00
`define ISS_NUM_ITER      3'h4

`endif

// file: logic/iss_pkg.sv
// Types shared by the iteration statistics unit and its output buffer.
package iss_pkg;

   // =======================================================================
   // Output select codes.
   typedef enum logic [1:0] {
      ISS_SEL_MAIN = 2'h0,
      ISS_SEL_PEAK = 2'h2,
      ISS_SEL_SUM  = 2'h3
   } iss_sel_t;

   // One datapath sample; last marks the final sample of an iteration.
   typedef struct packed {
      logic [23:0] i;
      logic [23:0] q;
      logic        last;
   } iss_sample_t;

   // One word to the output formatter; stat asks for two 32-bit words.
   typedef struct packed {
      logic [23:0] i;
      logic [23:0] q;
      logic        last;
      logic        stat;
   } iss_word_t;

endpackage

// file: logic/iss_stats.sv
// Per-iteration peak and sum statistics unit with its Avalon-MM registers.
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "iss_map.svh"

// ==========================================================================
module iss_stats (
   input  wire logic          mclk,            // Datapath clock, 25 MHz.
   input  wire logic          rst_b,           // Synchronous reset, active low.
   input  wire logic          ce,              // Clock enable; low freezes all.
   input  wire logic          in_valid,        // Datapath sample offered.
   output logic               in_ready,        // Unit takes the sample.
   input  iss_pkg::iss_sample_t in_data,       // Datapath I, Q and last flag.
   output logic               out_valid,       // Word to output formatter.
   input  wire logic          out_ready,       // Formatter takes the word.
   output iss_pkg::iss_word_t out_data,        // Word to output formatter.
   input  wire logic [7:0]    avs_address,     // Register byte address.
   input  wire logic          avs_read,        // Read request.
   input  wire logic          avs_write,       // Write request.
   input  wire logic [31:0]   avs_writedata,   // Write data.
   input  wire logic [3:0]    avs_byteenable,  // Write byte lanes.
   output logic [31:0]        avs_readdata,    // Read data.
   output logic               avs_waitrequest  // Stall, low for one answer cycle.
);

   // ========================================================================
   // Functions

   // Shift a 36-bit total right and clamp it into 24 signed bits.
   function automatic logic [23:0] sat_shift(input logic [35:0] tot, input logic [4:0] sh);
      logic signed [35:0] s;
      s = $signed(tot) >>> sh;
      if (s > 36'sh0007FFFFF) begin
         sat_shift = 24'h7FFFFF;
      end else if (s < -36'sh000800000) begin
         sat_shift = 24'h800000;
      end else begin
         sat_shift = s[23:0];
      end
   endfunction

   // Sign-extend a 24-bit sample to the width of the totals.
   function automatic logic [35:0] widen(input logic [23:0] v);
      widen = {{12{v[23]}}, v};
   endfunction

   // ========================================================================
   // Configuration state

   iss_pkg::iss_sel_t sel_reg;     // Output select field.
   logic              mag_reg;     // Magnitude computation enabled upstream.
   logic              log_reg;     // Log computation enabled upstream.
   logic [4:0]        shift_reg;   // Sum shift amount, not per parameter set.
   logic              restart;     // Write pulse that restarts recording.

   // ========================================================================
   // Accumulators of the running iteration

   logic [23:0] peak_reg;          // Largest sample so far.
   logic [11:0] pos_reg;           // Position of the largest sample.
   logic [11:0] idx_reg;           // Position of the next sample.
   logic [35:0] re_reg;            // Running real total.
   logic [35:0] im_reg;            // Running imaginary total.
   logic [23:0] peak_next;         // Peak including the current sample.
   logic [11:0] pos_next;          // Position including the current sample.
   logic [35:0] re_next;           // Real total including the current sample.
   logic [35:0] im_next;           // Imaginary total including the current sample.
   logic        take;              // Sample accepted this cycle.
   logic        iter_end;          // Accepted sample closes the iteration.

   // ========================================================================
   // Recorded results, one entry per early iteration

   logic [23:0] rec_peak [0:3];    // Recorded peak values.
   logic [11:0] rec_pos  [0:3];    // Recorded peak positions.
   logic [35:0] rec_re   [0:3];    // Recorded real totals.
   logic [35:0] rec_im   [0:3];    // Recorded imaginary totals.
   logic [2:0]  iter_cnt_reg;      // Iterations recorded, stops at four.

   // ========================================================================
   // Bus state

   logic        req;               // A read or write is pending.
   logic [31:0] rd_mux;            // Word selected by the address.
   logic [2:0]  blk;               // Result block field of the address.
   logic [1:0]  blk_n;             // Iteration that the block belongs to.

   // ========================================================================
   // Output buffer link

   logic               buf_valid;  // Word offered to the buffer.
   logic               buf_ready;  // Buffer has room.
   iss_pkg::iss_word_t buf_word;   // Word offered to the buffer.

   // ========================================================================
   // Sample intake

   // A sample is taken only when the buffer has room, so a stalled
   // formatter holds back the datapath instead of dropping a word.
   assign in_ready = buf_ready;
   assign take     = in_valid & buf_ready;
   assign iter_end = take & in_data.last;

   // Running values with the present sample folded in. The peak compares
   // unsigned, as magnitude and log samples never go negative.
   always_comb begin
      peak_next = peak_reg;
      pos_next  = pos_reg;
      re_next   = re_reg;
      im_next   = im_reg;
      if (take) begin
         // Strictly greater, so an equal later sample leaves the first.
         if ((mag_reg || log_reg) && in_data.i > peak_reg) begin
            peak_next = in_data.i;
            pos_next  = idx_reg;
         end
         // Both halves always add, giving a complex total.
         re_next = re_reg + widen(in_data.i);
         im_next = im_reg + widen(in_data.q);
      end
   end

   // Accumulators clear at the end of each iteration and on restart.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         peak_reg <= 24'h000000;
         pos_reg  <= 12'h000;
         idx_reg  <= 12'h000;
         re_reg   <= 36'h000000000;
         im_reg   <= 36'h000000000;
      end else if (ce) begin
         if (iter_end || restart) begin
            peak_reg <= 24'h000000;
            pos_reg  <= 12'h000;
            idx_reg  <= 12'h000;
            re_reg   <= 36'h000000000;
            im_reg   <= 36'h000000000;
         end else begin
            peak_reg <= peak_next;
            pos_reg  <= pos_next;
            re_reg   <= re_next;
            im_reg   <= im_next;
            if (take) begin
               idx_reg <= idx_reg + 12'h001;
            end
         end
      end
   end

   // ========================================================================
   // Result capture

   // The first four closing iterations land in the records; later ones
   // are seen only through the statistics output mode.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         iter_cnt_reg <= 3'h0;
      end else if (ce) begin
         if (restart) begin
            iter_cnt_reg <= 3'h0;
         end else if (iter_end && iter_cnt_reg != `ISS_NUM_ITER) begin
            iter_cnt_reg <= iter_cnt_reg + 3'h1;
         end
      end
   end

   // Records keep their values over a restart until overwritten.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int n = 0; n < 4; n++) begin
            rec_peak[n] <= 24'h000000;
            rec_pos[n]  <= 12'h000;
            rec_re[n]   <= 36'h000000000;
            rec_im[n]   <= 36'h000000000;
         end
      end else if (ce && !restart && iter_end && iter_cnt_reg != `ISS_NUM_ITER) begin
         rec_peak[iter_cnt_reg[1:0]] <= peak_next;
         rec_pos[iter_cnt_reg[1:0]]  <= pos_next;
         rec_re[iter_cnt_reg[1:0]]   <= re_next;
         rec_im[iter_cnt_reg[1:0]]   <= im_next;
      end
   end

   // ========================================================================
   // Output path

   // Main mode forwards every sample; statistics mode swallows samples
   // and sends one word when the iteration closes.
   always_comb begin
      buf_valid     = 1'b0;
      buf_word      = '0;
      buf_word.last = in_data.last;
      if (!sel_reg[1]) begin
         buf_valid  = in_valid;
         buf_word.i = in_data.i;
         buf_word.q = in_data.q;
      end else begin
         buf_valid     = in_valid & in_data.last;
         // The formatter writes this as two 32-bit words and ignores the
         // usual destination count, stride, width and real-only flag.
         buf_word.stat = 1'b1;
         if (!sel_reg[0]) begin
            buf_word.i = peak_next;
            buf_word.q = {12'h000, pos_next};
         end else begin
            // Shift then clamp signed, even for magnitude totals.
            buf_word.i = sat_shift(re_next, shift_reg);
            buf_word.q = sat_shift(im_next, shift_reg);
         end
      end
   end

   // The buffer absorbs one stalled word so the formatter's stall costs
   // no sample; its flags are flip-flops, keeping outputs registered.
   iss_buf2 u_buf (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .ce        (ce),
      .in_valid  (buf_valid),
      .in_ready  (buf_ready),
      .in_data   (buf_word),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );

   // ========================================================================
   // Avalon-MM slave

   assign req   = avs_read | avs_write;
   assign blk   = avs_address[7:5];
   assign blk_n = 2'(blk - `ISS_RES_FIRST);

   // Read decode; unmapped addresses answer zero.
   always_comb begin
      rd_mux = 32'h00000000;
      if (avs_address == `ISS_CTRL_OFS) begin
         rd_mux[`ISS_SEL_LSB +: 2]   = sel_reg;
         rd_mux[`ISS_MAG_BIT]        = mag_reg;
         rd_mux[`ISS_LOG_BIT]        = log_reg;
         rd_mux[`ISS_SHIFT_LSB +: 5] = shift_reg;
      end else if (avs_address == `ISS_STAT_OFS) begin
         rd_mux[2:0] = iter_cnt_reg;
         rd_mux[4]   = (idx_reg != 12'h000);
      end else if (blk >= `ISS_RES_FIRST && blk <= `ISS_RES_LAST && avs_address[1:0] == 2'h0) begin
         case (avs_address[4:2])
            `ISS_SLOT_PEAK:  rd_mux[23:0] = rec_peak[blk_n];
            `ISS_SLOT_POS:   rd_mux[11:0] = rec_pos[blk_n];
            `ISS_SLOT_RE_LO: rd_mux       = rec_re[blk_n][31:0];
            `ISS_SLOT_RE_HI: rd_mux[3:0]  = rec_re[blk_n][35:32];
            `ISS_SLOT_IM_LO: rd_mux       = rec_im[blk_n][31:0];
            `ISS_SLOT_IM_HI: rd_mux[3:0]  = rec_im[blk_n][35:32];
            default:         rd_mux       = 32'h00000000;
         endcase
      end
   end

   // One wait cycle: waitrequest drops for one cycle after a request is
   // seen, and rises again at the edge that completes the transfer.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else if (ce) begin
         if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : 32'h00000000;
         end else begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   // Restart is a write of one to its bit; it reads back as zero.
   assign restart = avs_write & ~avs_waitrequest & (avs_address == `ISS_CTRL_OFS)
                    & avs_byteenable[3] & avs_writedata[`ISS_RESTART_BIT];

   // Control register; writes land at the completing edge, per byte lane.
   // Result records are read-only, so writes to them are dropped.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sel_reg   <= iss_pkg::iss_sel_t'(`ISS_SEL_RST);
         mag_reg   <= 1'b0;
         log_reg   <= 1'b0;
         shift_reg <= `ISS_SHIFT_RST;
      end else if (ce && avs_write && !avs_waitrequest && avs_address == `ISS_CTRL_OFS) begin
         if (avs_byteenable[0]) begin
            sel_reg <= iss_pkg::iss_sel_t'(avs_writedata[`ISS_SEL_LSB +: 2]);
            mag_reg <= avs_writedata[`ISS_MAG_BIT];
            log_reg <= avs_writedata[`ISS_LOG_BIT];
         end
         if (avs_byteenable[1]) begin
            shift_reg <= avs_writedata[`ISS_SHIFT_LSB +: 5];
         end
      end
   end

endmodule
